/* File: hw/adctr_pkg.sv */
package adctr_pkg;

  localparam int NUM_UNITS = 2;
  localparam int RES_W     = 10;
  localparam int CH_W      = 2;
  localparam int CNT_W     = 9;

  // Conversion length in system clock states, first-conversion worst case.
  localparam int CONV_STATES = 266;

  localparam logic [4:0] OFS_CSR0 = 5'h00;
  localparam logic [4:0] OFS_CSR1 = 5'h04;
  localparam logic [4:0] OFS_TRG  = 5'h08;
  localparam logic [4:0] OFS_RES0 = 5'h0c;
  localparam logic [4:0] OFS_RES1 = 5'h10;
  localparam logic [4:0] OFS_STS  = 5'h14;
  localparam logic [4:0] OFS_MASK = 5'h18;

  localparam int CSR_FLAG  = 7;
  localparam int CSR_IE    = 6;
  localparam int CSR_START = 5;
  localparam int CSR_SCAN  = 4;
  localparam int CSR_CH_LO = 0;

  localparam int TRG_EN0    = 0;
  localparam int TRG_EN1    = 1;
  localparam int TRG_DMACLR = 2;

  localparam int UNIT_DTC = 0;
  localparam int UNIT_DMA = 1;

  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    ADCTR_IDLE = 2'b01,
    ADCTR_CONV = 2'b10
  } adctr_state_e;

endpackage

/* File: hw/adctr_unit_if.sv */
`timescale 1ns/1ns
interface adctr_unit_if
  import adctr_pkg::*;
();
  logic             start;
  logic             scan;
  logic [CH_W-1:0]  chans;
  logic             done;
  logic [RES_W-1:0] result;

  modport ctl  (output start, output scan, output chans, input done, input result);
  modport unit (input start, input scan, input chans, output done, output result);
endinterface

/* File: hw/adctr_unit.sv */
`timescale 1ns/1ns
module adctr_unit
  import adctr_pkg::*;
#(
  parameter int CONV_CYC = CONV_STATES
) (
  input  wire logic             pclk,        // System clock.
  input  wire logic             presetn,     // Asynchronous reset, active low.
  input  wire logic [RES_W-1:0] analog_code, // Digitised sample of the comparator.
  adctr_unit_if.unit            u            // Control side of the unit.
);

  typedef struct packed {
    adctr_state_e     state;
    logic [CNT_W-1:0] cnt;
    logic [CH_W-1:0]  chan;
    logic             done;
    logic [RES_W-1:0] result;
  } adctr_unit_s;

  localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(CONV_CYC - 1);

  adctr_unit_s r_ff;
  adctr_unit_s nxt_r;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_r      = r_ff;
    nxt_r.done = 1'b0;
    unique case (r_ff.state)
      ADCTR_IDLE: begin
        nxt_r.cnt  = '0;
        nxt_r.chan = '0;
        if (u.start) begin
          nxt_r.state = ADCTR_CONV;
        end
      end
      ADCTR_CONV: begin
        // Clearing the start bit aborts; no partial result is reported.
        if (!u.start) begin
          nxt_r.state = ADCTR_IDLE;
        end else if (r_ff.cnt == LAST_CNT) begin
          nxt_r.cnt    = '0;
          nxt_r.result = analog_code;
          if (!u.scan || r_ff.chan == u.chans) begin
            nxt_r.done  = 1'b1;
            nxt_r.chan  = '0;
            nxt_r.state = u.scan ? ADCTR_CONV : ADCTR_IDLE;
          end else begin
            nxt_r.chan = r_ff.chan + 1'b1;
          end
        end else begin
          nxt_r.cnt = r_ff.cnt + 1'b1;
        end
      end
      default: begin
        nxt_r.state = ADCTR_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= '{state: ADCTR_IDLE, cnt: '0, chan: '0, done: 1'b0, result: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign u.done   = r_ff.done;
  assign u.result = r_ff.result;

endmodule

/* File: hw/adctr_trigger_req.sv */
`timescale 1ns/1ns
module adctr_trigger_req
  import adctr_pkg::*;
#(
  parameter int CONV_CYC = CONV_STATES
) (
  input  wire logic             pclk,                 // System clock, 50 MHz.
  input  wire logic             presetn,              // Asynchronous reset, active low.
  input  wire logic             psel,                 // APB select.
  input  wire logic             penable,              // APB access phase.
  input  wire logic             pwrite,               // APB write.
  input  wire logic [31:0]      paddr,                // APB byte address.
  input  wire logic [31:0]      pwdata,               // APB write data.
  output logic                  pready,               // APB ready.
  output logic [31:0]           prdata,               // APB read data.
  output logic                  pslverr,              // APB error on unmapped address.
  input  wire logic             ext_conv_trigger_n,   // Trigger pin, asynchronous, low.
  input  wire logic             multi_function_timer_trigger, // Timer trigger pulse.
  input  wire logic [RES_W-1:0] analog_code_u0,       // Comparator code of unit zero.
  input  wire logic [RES_W-1:0] analog_code_u1,       // Comparator code of unit one.
  input  wire logic             dtc_reg_access_u0,    // Transfer controller touched unit zero.
  input  wire logic             dma_reg_access_u1,    // DMA touched unit one.
  output logic                  conv_done_irq_u0,     // Unit zero request to the CPU.
  output logic                  conv_done_irq_u1,     // Unit one request to the CPU.
  output logic                  dtc_req,              // Activation of the transfer controller.
  output logic                  dma_req,              // Activation of the DMA controller.
  output logic                  irq                   // Level interrupt from status and mask.
);

  typedef struct packed {
    logic [2:0]           trg_sync;
    logic [NUM_UNITS-1:0] trg_en;
    logic                 dma_clr_en;
    logic [NUM_UNITS-1:0] start;
    logic [NUM_UNITS-1:0] ie;
    logic [NUM_UNITS-1:0] flag;
    logic [NUM_UNITS-1:0] armed;
    logic [NUM_UNITS-1:0] scan;
    logic [2*CH_W-1:0]    chans;
    logic [NUM_UNITS-1:0] sts;
    logic [NUM_UNITS-1:0] mask;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
    logic                 irq_u0;
    logic                 irq_u1;
    logic                 dtc_req;
    logic                 dma_req;
    logic                 irq;
  } adctr_top_s;

  adctr_top_s r_ff;
  adctr_top_s nxt_r;

  adctr_unit_if u_if[NUM_UNITS] ();

  logic [RES_W-1:0]     res     [NUM_UNITS];
  logic [NUM_UNITS-1:0] done;

  ////////////////////////////////////////////////////////////////////////////
  // Two conversion units share the triggers and differ only in their request path.
  adctr_unit #(.CONV_CYC(CONV_CYC)) u_unit0 (
    .pclk        (pclk),
    .presetn     (presetn),
    .analog_code (analog_code_u0),
    .u           (u_if[0])
  );

  adctr_unit #(.CONV_CYC(CONV_CYC)) u_unit1 (
    .pclk        (pclk),
    .presetn     (presetn),
    .analog_code (analog_code_u1),
    .u           (u_if[1])
  );

  for (genvar g = 0; g < NUM_UNITS; g++) begin : g_unit
    // A single conversion's done pulse hides the start bit for that cycle.
    // Otherwise the idle unit would restart before the bit clears.
    assign u_if[g].start = r_ff.start[g] && !(done[g] && !r_ff.scan[g]);
    assign u_if[g].scan  = r_ff.scan[g];
    assign u_if[g].chans = r_ff.chans[g*CH_W +: CH_W];
    assign done[g]       = u_if[g].done;
    assign res[g]        = u_if[g].result;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] csr_word(input adctr_top_s s, input int i);
    logic [31:0] w;
    w                       = RD_ZERO;
    w[CSR_FLAG]             = s.flag[i];
    w[CSR_IE]               = s.ie[i];
    w[CSR_START]            = s.start[i];
    w[CSR_SCAN]             = s.scan[i];
    w[CSR_CH_LO +: CH_W]    = s.chans[i*CH_W +: CH_W];
    return w;
  endfunction

  function automatic logic mapped(input logic [4:0] a);
    return a == OFS_CSR0 || a == OFS_CSR1 || a == OFS_TRG || a == OFS_RES0 ||
           a == OFS_RES1 || a == OFS_STS || a == OFS_MASK;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic             hw_trig;
  logic             acc_done;
  logic             hit;
  logic [4:0]       a;
  logic [31:0]      rd;
  int               ui;

  always_comb begin
    nxt_r = r_ff;
    a     = paddr[4:0];
    hit   = mapped(a) && paddr[31:5] == '0;
    rd    = RD_ZERO;
    ui    = (a == OFS_CSR1) ? 1 : 0;

    // Only the second stage is read; the third is its delayed copy for the edge.
    nxt_r.trg_sync = {r_ff.trg_sync[1:0], ext_conv_trigger_n};
    hw_trig = |r_ff.trg_en &&
              ((r_ff.trg_sync[2] && !r_ff.trg_sync[1]) || multi_function_timer_trigger);

    // One wait state: data is prepared, then pready is shown for one cycle.
    acc_done       = psel && penable && r_ff.pready;
    nxt_r.pready   = psel && penable && !r_ff.pready;
    nxt_r.pslverr  = psel && penable && !r_ff.pready && !hit;
    unique case (a)
      OFS_CSR0, OFS_CSR1: rd = csr_word(r_ff, ui);
      OFS_TRG:  rd = {29'h0000_0000, r_ff.dma_clr_en, r_ff.trg_en};
      OFS_RES0: rd = {22'h00_0000, res[0]};
      OFS_RES1: rd = {22'h00_0000, res[1]};
      OFS_STS:  rd = {30'h0000_0000, r_ff.sts};
      OFS_MASK: rd = {30'h0000_0000, r_ff.mask};
      default:  rd = RD_ZERO;
    endcase
    nxt_r.prdata = (psel && penable && !r_ff.pready && !pwrite && hit) ? rd : RD_ZERO;

    // Register effects happen only at the edge that completes the transfer.
    if (acc_done && hit) begin
      if (pwrite) begin
        unique case (a)
          OFS_CSR0, OFS_CSR1: begin
            nxt_r.ie[ui]                   = pwdata[CSR_IE];
            nxt_r.start[ui]                = pwdata[CSR_START];
            nxt_r.scan[ui]                 = pwdata[CSR_SCAN];
            nxt_r.chans[ui*CH_W +: CH_W]   = pwdata[CSR_CH_LO +: CH_W];
            if (!pwdata[CSR_FLAG] && r_ff.armed[ui]) begin
              nxt_r.flag[ui] = 1'b0;
            end
            nxt_r.armed[ui] = 1'b0;
          end
          OFS_TRG: begin
            nxt_r.trg_en     = pwdata[TRG_EN1:TRG_EN0];
            nxt_r.dma_clr_en = pwdata[TRG_DMACLR];
          end
          OFS_MASK: nxt_r.mask = pwdata[NUM_UNITS-1:0];
          default: ;
        endcase
      end else begin
        if ((a == OFS_CSR0 || a == OFS_CSR1) && r_ff.flag[ui]) begin
          nxt_r.armed[ui] = 1'b1;
        end
        if (a == OFS_STS) begin
          nxt_r.sts = '0;
        end
      end
    end

    if (dtc_reg_access_u0) begin
      nxt_r.flag[UNIT_DTC] = 1'b0;
    end
    if (dma_reg_access_u1 && r_ff.dma_clr_en) begin
      nxt_r.flag[UNIT_DMA] = 1'b0;
    end

    if (hw_trig) begin
      nxt_r.start = '1;
    end

    // Completion is applied last so a done event always beats a clear.
    for (int i = 0; i < NUM_UNITS; i++) begin
      if (done[i]) begin
        nxt_r.flag[i] = 1'b1;
        nxt_r.sts[i]  = 1'b1;
        if (!r_ff.scan[i] && !hw_trig) begin
          nxt_r.start[i] = 1'b0;
        end
      end
    end

    nxt_r.irq_u0  = nxt_r.flag[UNIT_DTC] && nxt_r.ie[UNIT_DTC];
    nxt_r.irq_u1  = nxt_r.flag[UNIT_DMA] && nxt_r.ie[UNIT_DMA];
    nxt_r.dtc_req = nxt_r.irq_u0;
    nxt_r.dma_req = nxt_r.irq_u1;
    nxt_r.irq     = |(nxt_r.sts & nxt_r.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff          <= '0;
      r_ff.trg_sync <= 3'h7;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign pready           = r_ff.pready;
  assign prdata           = r_ff.prdata;
  assign pslverr          = r_ff.pslverr;
  assign conv_done_irq_u0 = r_ff.irq_u0;
  assign conv_done_irq_u1 = r_ff.irq_u1;
  assign dtc_req          = r_ff.dtc_req;
  assign dma_req          = r_ff.dma_req;
  assign irq              = r_ff.irq;

endmodule

/* File: verification/adctr_trigger_req_props.sv */
`timescale 1ns/1ns
module adctr_trigger_req_props
  import adctr_pkg::*;
#(
  parameter int CONV_CYC = CONV_STATES
) (
  input wire logic        pclk,              // System clock.
  input wire logic        presetn,           // Reset, active low.
  input wire logic        psel,              // APB select.
  input wire logic        penable,           // APB access phase.
  input wire logic        pready,            // APB ready.
  input wire logic [31:0] prdata,            // APB read data.
  input wire logic        pslverr,           // APB error.
  input wire logic        dtc_reg_access_u0, // Transfer controller access.
  input wire logic        conv_done_irq_u0,  // Unit zero request.
  input wire logic        conv_done_irq_u1,  // Unit one request.
  input wire logic        dtc_req,           // Transfer controller activation.
  input wire logic        dma_req            // DMA activation.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  chk_ready_one_wait: assert property (s_wait |=> s_answer)
    else $error("pready not one cycle after access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than a cycle");
  chk_ready_has_req: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  chk_dtc_unit_zero: assert property (dtc_req == conv_done_irq_u0)
    else $error("transfer request not from unit zero");
  chk_dma_unit_one: assert property (dma_req == conv_done_irq_u1)
    else $error("dma request not from unit one");
  chk_dtc_clears_flag: assert property (dtc_reg_access_u0 |-> ##2 !conv_done_irq_u0)
    else $error("transfer access left flag set");
endmodule

/* File: verification/adctr_xfer_model.sv */
`timescale 1ns/1ns
module adctr_xfer_model (
  input  wire logic pclk,    // System clock.
  input  wire logic presetn, // Reset, active low.
  input  wire logic en,      // Serve requests while high.
  input  wire logic dtc_req, // Transfer controller activation.
  input  wire logic dma_req, // DMA activation.
  output logic      dtc_acc, // Transfer controller touches unit zero.
  output logic      dma_acc  // DMA touches unit one.
);
  logic dtc_seen_ff;
  logic dma_seen_ff;
  // One access per rising request, so a slow flag clear cannot cause a second access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dtc_seen_ff <= 1'b0;
      dma_seen_ff <= 1'b0;
      dtc_acc     <= 1'b0;
      dma_acc     <= 1'b0;
    end else begin
      dtc_seen_ff <= dtc_req;
      dma_seen_ff <= dma_req;
      dtc_acc     <= en && dtc_req && !dtc_seen_ff;
      dma_acc     <= en && dma_req && !dma_seen_ff;
    end
  end
endmodule

/* File: verification/adctr_trigger_req_tb.sv */
`timescale 1ns/1ns
module adctr_trigger_req_tb
  import adctr_pkg::*;
;
  localparam int CC = 8;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0]      paddr = 32'h0, pwdata = 32'h0, prdata, q;
  logic             pready, pslverr, e, trg_n = 1'b1, tmr = 1'b0, xen = 1'b0;
  logic [RES_W-1:0] code0 = 10'h2a5, code1 = 10'h15a;
  logic             dtc_acc, dma_acc, irq0, irq1, dtc_req, dma_req, irq;
  int               failures = 0, check_count = 0;
  always #10 pclk = ~pclk;
  adctr_trigger_req #(.CONV_CYC(CC)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_conv_trigger_n(trg_n), .multi_function_timer_trigger(tmr),
    .analog_code_u0(code0), .analog_code_u1(code1), .dtc_reg_access_u0(dtc_acc),
    .dma_reg_access_u1(dma_acc), .conv_done_irq_u0(irq0), .conv_done_irq_u1(irq1),
    .dtc_req(dtc_req), .dma_req(dma_req), .irq(irq));
  adctr_xfer_model far (.pclk(pclk), .presetn(presetn), .en(xen), .dtc_req(dtc_req),
    .dma_req(dma_req), .dtc_acc(dtc_acc), .dma_acc(dma_acc));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] got);
    check_count++;
    if (got !== x) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, x, got);
    end
  endtask
  // Each transfer starts on a fresh edge so the release of the last one never collides.
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    cmp(nm, x, q);
  endtask
  task automatic wcyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    conclude();
  end
  initial begin
    int n;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CSR0, 32'h0, "csr0 reset");
    rd(OFS_TRG, 32'h0, "trg reset");
    rd(32'h1c, 32'h0, "unmapped data");
    cmp("unmapped err", 32'h1, {31'h0, e});
    $display("test reset done");
    wr(OFS_CSR0, 32'h20);
    wcyc(CC + 8);
    cmp("irq0 masked", 32'h0, {31'h0, irq0});
    wr(OFS_CSR0, 32'h0);
    rd(OFS_CSR0, 32'h80, "csr0 unarmed clear");
    wr(OFS_CSR0, 32'h0);
    rd(OFS_CSR0, 32'h0, "csr0 armed clear");
    rd(OFS_RES0, {22'h0, code0}, "res0");
    cmp("irq unmasked off", 32'h0, {31'h0, irq});
    wr(OFS_MASK, 32'h1);
    wcyc(2);
    cmp("irq raised", 32'h1, {31'h0, irq});
    rd(OFS_STS, 32'h1, "sts sticky");
    wcyc(2);
    cmp("irq cleared", 32'h0, {31'h0, irq});
    $display("test software start done");
    wr(OFS_CSR0, 32'h60);
    n = 0;
    while (irq0 !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    cmp("irq0 waited", 32'h0, {31'h0, n >= 100});
    rd(OFS_CSR0, 32'hc0, "csr0 flag set");
    wr(OFS_CSR0, 32'h40);
    rd(OFS_CSR0, 32'h40, "csr0 flag off");
    $display("test enabled request done");
    trg_n <= 1'b0;
    tmr   <= 1'b1;
    @(posedge pclk);
    tmr <= 1'b0;
    wcyc(6);
    trg_n <= 1'b1;
    rd(OFS_CSR0, 32'h40, "csr0 trigger off");
    rd(OFS_CSR1, 32'h0, "csr1 trigger off");
    xen <= 1'b1;
    wr(OFS_CSR1, 32'h40);
    wr(OFS_TRG, 32'h6);
    rd(OFS_STS, 32'h1, "sts before trigger");
    trg_n <= 1'b0;
    wcyc(4);
    rd(OFS_CSR0, 32'h60, "csr0 pin start");
    wcyc(CC + 12);
    trg_n <= 1'b1;
    rd(OFS_CSR0, 32'h40, "csr0 dtc clear");
    rd(OFS_CSR1, 32'h40, "csr1 dma clear");
    rd(OFS_STS, 32'h3, "sts both done");
    cmp("irq1 after dma clear", 32'h0, {31'h0, irq1});
    cmp("dma req after clear", 32'h0, {31'h0, dma_req});
    rd(OFS_RES1, {22'h0, code1}, "res1");
    $display("test pin trigger done");
    wr(OFS_CSR0, 32'h51);
    tmr <= 1'b1;
    @(posedge pclk);
    tmr <= 1'b0;
    wcyc(2);
    rd(OFS_CSR0, 32'h71, "csr0 timer scan");
    wr(OFS_CSR0, 32'h50);
    wcyc(CC + 4);
    rd(OFS_CSR0, 32'h50, "csr0 scan abort");
    $display("test timer trigger done");
    conclude();
  end
endmodule
bind adctr_trigger_req adctr_trigger_req_props #(.CONV_CYC(CONV_CYC)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .dtc_reg_access_u0(dtc_reg_access_u0),
  .conv_done_irq_u0(conv_done_irq_u0), .conv_done_irq_u1(conv_done_irq_u1),
  .dtc_req(dtc_req), .dma_req(dma_req));
